// >>> core/qirq_device.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// Queue interrupt status, receive frame threshold and transmit space request.
// -----------------------------------------------------------------------------
// Behaviour
// - Transmit space flag bit 6, write-one clears.
// - Wake frame flag bit 5, cleared by 1000.
// - Wake packet flag bit 4, cleared by 0100.
// - Link-up wake flag bit 3, cleared by 0010.
// - Energy wake flag bit 2, cleared by 0001.
// - Enable bits 2 and 0 select delayed energy.
// - Serial bus error sets flag bit 1.
// - Serial error flag sticky until write-one.
// - Bits 15-8 report queued frames at interrupt.
// - Writable 8-bit frame threshold, reset zero.
// - Control bit 5 enables above-threshold receive interrupt.
// - Host programs requested transmit space in dwords.
// - Monitor bit 1 raises bit 6 on space.
// - Host reads count, then frame header registers; this block has no frame header registers.
// - Interrupt pin high for any enabled status.
// - Reads never clear; only written ones clear.
module qirq_device import qirq_pkg::*; #(
  parameter int CNT_W = 8, // Width of the queued frame count.
  parameter int SIZE_W = 16 // Width of the transmit space request.
) (
  input wire logic aclk,
  input wire logic aresetn,
  qirq_if.dev bus,
  input wire logic wake_frame_evt,
  input wire logic wake_packet_evt,
  input wire logic linkup_evt,
  input wire logic energy_evt,
  input wire logic serial_err_evt,
  input wire logic [CNT_W-1:0] rx_frames_level,
  input wire logic [SIZE_W-1:0] tx_free_dwords,
  output logic irq,
  output logic energy_plain,
  output logic energy_delayed
);

  // ---------------------------------------------------------------------------
  // State of the block.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] int_enable; // Interrupt enable register.
    logic [15:0] int_status; // Sticky status bits.
    logic [CNT_W-1:0] rx_frames_queued; // Count caught at the receive interrupt.
    logic [CNT_W-1:0] rx_frames_threshold; // Programmed threshold.
    logic [SIZE_W-1:0] tx_request_size; // Requested transmit space.
    logic [15:0] tx_queue_control; // Transmit queue control.
    logic [15:0] rx_queue_control; // Receive queue control.
    logic [15:0] power_event_control; // Stored power event bits.
    logic rx_above_q; // Threshold condition, last cycle.
    logic tx_space_q; // Space condition, last cycle.
    logic ack; // Access answer pulse.
    logic [15:0] rdata; // Read data.
    logic irq; // Interrupt pin.
    logic energy_plain; // Plain energy wake indication.
    logic energy_delayed; // Delayed energy wake indication.
  } qirq_dev_state_t;

  qirq_dev_state_t state; // Registered state.
  qirq_dev_state_t next_state; // Next state.
  logic access; // A new request is being served.
  logic rx_above; // Queued frames above threshold while enabled.
  logic tx_space; // Requested space free while monitored.
  logic [15:0] set_bits; // Status bits set this cycle.
  logic [15:0] clr_bits; // Status bits cleared this cycle.
  logic [15:0] rd_value; // Value of the addressed register.

  // ---------------------------------------------------------------------------
  // Read decode; unmapped offsets read as zero.
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_value = REG_RESET;
    unique case (bus.addr)
      OFS_INT_ENABLE: begin
        rd_value = state.int_enable;
      end
      OFS_INT_STATUS: begin
        // Plain read, the status is left untouched.
        rd_value = state.int_status;
      end
      OFS_RX_FRAME_COUNT_THRESHOLD: begin
        rd_value = 16'({state.rx_frames_queued, state.rx_frames_threshold});
      end
      OFS_TX_NEXT_REQUEST_SIZE: begin
        rd_value = 16'(state.tx_request_size);
      end
      OFS_TX_QUEUE_CONTROL: begin
        rd_value = state.tx_queue_control;
      end
      OFS_RX_QUEUE_CONTROL: begin
        rd_value = state.rx_queue_control;
      end
      OFS_POWER_EVENT_CONTROL: begin
        rd_value = state.power_event_control;
      end
      default: begin
        rd_value = REG_RESET;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state: register writes, event capture and interrupt pin.
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    set_bits = '0;
    clr_bits = '0;
    // A request is served once; the held request during ack is ignored.
    access = bus.req && !state.ack;

    // Threshold and space conditions, each gated by its control bit.
    rx_above = state.rx_queue_control[BIT_RX_THRESHOLD_EN] &&
      (rx_frames_level > state.rx_frames_threshold);
    tx_space = state.tx_queue_control[BIT_TX_SPACE_MON] &&
      (tx_free_dwords >= state.tx_request_size);
    next_state.rx_above_q = rx_above;
    next_state.tx_space_q = tx_space;

    // Conditions set their flags on the rising edge, so a cleared flag
    // is not set again while the condition merely stays true.
    set_bits[BIT_RX_INT] = rx_above && !state.rx_above_q;
    set_bits[BIT_TX_SPACE] = tx_space && !state.tx_space_q;
    set_bits[BIT_WAKE_FRAME] = wake_frame_evt;
    set_bits[BIT_WAKE_PACKET] = wake_packet_evt;
    set_bits[BIT_LINKUP_WAKE] = linkup_evt;
    set_bits[BIT_ENERGY_WAKE] = energy_evt;
    set_bits[BIT_SERIAL_ERR] = serial_err_evt;

    if (access) begin
      next_state.ack = 1'b1;
      if (bus.we) begin
        unique case (bus.addr)
          OFS_INT_ENABLE: begin
            next_state.int_enable = bus.wdata;
          end
          OFS_INT_STATUS: begin
            // Only written ones on clearable bits take effect.
            clr_bits = bus.wdata & STATUS_W1C_MASK;
          end
          OFS_RX_FRAME_COUNT_THRESHOLD: begin
            // The count half is read-only.
            next_state.rx_frames_threshold = bus.wdata[CNT_W-1:0];
          end
          OFS_TX_NEXT_REQUEST_SIZE: begin
            next_state.tx_request_size = bus.wdata[SIZE_W-1:0];
          end
          OFS_TX_QUEUE_CONTROL: begin
            next_state.tx_queue_control = bus.wdata;
          end
          OFS_RX_QUEUE_CONTROL: begin
            next_state.rx_queue_control = bus.wdata;
          end
          OFS_POWER_EVENT_CONTROL: begin
            // The clear field acts as a command and is not stored.
            next_state.power_event_control = bus.wdata & ~PEC_CLR_FIELD;
            unique case (bus.wdata[PEC_CLR_LSB +: 4])
              PEC_CLR_WAKE_FRAME: begin
                clr_bits[BIT_WAKE_FRAME] = 1'b1;
              end
              PEC_CLR_WAKE_PACKET: begin
                clr_bits[BIT_WAKE_PACKET] = 1'b1;
              end
              PEC_CLR_LINKUP: begin
                clr_bits[BIT_LINKUP_WAKE] = 1'b1;
              end
              PEC_CLR_ENERGY: begin
                clr_bits[BIT_ENERGY_WAKE] = 1'b1;
              end
              default: begin
                // Other patterns clear nothing.
              end
            endcase
          end
          default: begin
            // Writes to unmapped offsets are dropped.
          end
        endcase
      end else begin
        next_state.rdata = rd_value;
      end
    end

    // A set in the same cycle as a clear wins.
    next_state.int_status = ((state.int_status & ~clr_bits) | set_bits) & STATUS_IMPL_MASK;

    // The queued count is caught as the receive interrupt occurs.
    if (set_bits[BIT_RX_INT]) begin
      next_state.rx_frames_queued = rx_frames_level;
    end

    // Interrupt pin follows any enabled status bit.
    next_state.irq = |(next_state.int_status & next_state.int_enable);

    // Meaning of the energy flag depends on the two energy enables.
    next_state.energy_plain = next_state.int_status[BIT_ENERGY_WAKE] &&
      next_state.int_enable[BIT_ENERGY_WAKE] && !next_state.int_enable[BIT_DELAY_ENERGY_EN];
    next_state.energy_delayed = next_state.int_status[BIT_ENERGY_WAKE] &&
      next_state.int_enable[BIT_ENERGY_WAKE] && next_state.int_enable[BIT_DELAY_ENERGY_EN];
  end

  // ---------------------------------------------------------------------------
  // State register with synchronous reset to zero.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, each straight from a flip-flop.
  // ---------------------------------------------------------------------------
  assign bus.ack = state.ack;
  assign bus.rdata = state.rdata;
  assign bus.irq = state.irq;
  assign irq = state.irq;
  assign energy_plain = state.energy_plain;
  assign energy_delayed = state.energy_delayed;

endmodule

// >>> core/qirq_pkg.sv
// -----------------------------------------------------------------------------
// Shared constants of the queue interrupt block and its host controller.
// -----------------------------------------------------------------------------
package qirq_pkg;

  // ---------------------------------------------------------------------------
  // Device register byte offsets on the register port.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_TX_QUEUE_CONTROL = 8'h80; // Transmit queue control.
  localparam logic [7:0] OFS_RX_QUEUE_CONTROL = 8'h82; // Receive queue control.
  localparam logic [7:0] OFS_INT_ENABLE = 8'h90; // Interrupt enable register.
  localparam logic [7:0] OFS_INT_STATUS = 8'h92; // Interrupt status, low half.
  localparam logic [7:0] OFS_RX_FRAME_COUNT_THRESHOLD = 8'h9C; // Count and threshold.
  localparam logic [7:0] OFS_TX_NEXT_REQUEST_SIZE = 8'h9E; // Requested transmit space.
  localparam logic [7:0] OFS_POWER_EVENT_CONTROL = 8'hD4; // Power event control.

  // ---------------------------------------------------------------------------
  // Interrupt status and enable bit positions.
  // ---------------------------------------------------------------------------
  localparam int BIT_RX_INT = 13; // Receive frame threshold interrupt.
  localparam int BIT_TX_SPACE = 6; // Transmit space available.
  localparam int BIT_WAKE_FRAME = 5; // Wake frame detected.
  localparam int BIT_WAKE_PACKET = 4; // Wake packet detected.
  localparam int BIT_LINKUP_WAKE = 3; // Link-up wake.
  localparam int BIT_ENERGY_WAKE = 2; // Energy detect wake.
  localparam int BIT_SERIAL_ERR = 1; // Serial bus error.
  localparam int BIT_DELAY_ENERGY_EN = 0; // Delayed energy detect enable.
  localparam int BIT_RX_THRESHOLD_EN = 5; // Receive queue control threshold enable.
  localparam int BIT_TX_SPACE_MON = 1; // Transmit queue space monitor enable.

  // Status bits that exist, and those cleared by writing a one.
  localparam logic [15:0] STATUS_IMPL_MASK = 16'h207E;
  localparam logic [15:0] STATUS_W1C_MASK = 16'h2042;

  // ---------------------------------------------------------------------------
  // Power event control: bits 5 to 2 carry wake clear patterns.
  // ---------------------------------------------------------------------------
  localparam int PEC_CLR_LSB = 2; // Low bit of the clear field.
  localparam logic [15:0] PEC_CLR_FIELD = 16'h003C; // Clear field, never stored.
  localparam logic [3:0] PEC_CLR_WAKE_FRAME = 4'h8; // Pattern 1000.
  localparam logic [3:0] PEC_CLR_WAKE_PACKET = 4'h4; // Pattern 0100.
  localparam logic [3:0] PEC_CLR_LINKUP = 4'h2; // Pattern 0010.
  localparam logic [3:0] PEC_CLR_ENERGY = 4'h1; // Pattern 0001.

  // Reset value of every device register.
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ---------------------------------------------------------------------------
  // Host controller AXI4-Lite byte offsets, fields and responses.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] HOFS_COMMAND = 4'h0; // Command: write flag, address, data.
  localparam logic [3:0] HOFS_STATUS = 4'h4; // Busy flag and last read data.
  localparam logic [3:0] HOFS_IRQ_STATUS = 4'h8; // Sticky events, write one to clear.
  localparam logic [3:0] HOFS_IRQ_MASK = 4'hC; // Event mask.
  localparam int HCMD_WRITE_BIT = 31; // Command is a register write.
  localparam int HSTAT_BUSY_BIT = 16; // Access under way.
  localparam int HEV_DONE = 0; // Register access finished.
  localparam int HEV_DEV_IRQ = 1; // Device interrupt line rose.
  localparam logic [1:0] AXI_OKAY = 2'h0; // Normal response.
  localparam logic [1:0] AXI_SLVERR = 2'h2; // Unmapped address response.

endpackage

// >>> core/qirq_if.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// Register port between the host controller and the device.
// -----------------------------------------------------------------------------
interface qirq_if;

  logic req; // Host holds this high until ack.
  logic we; // High for a register write.
  logic [7:0] addr; // Register byte offset.
  logic [15:0] wdata; // Write data.
  logic ack; // One-cycle pulse, access done.
  logic [15:0] rdata; // Read data, valid with ack.
  logic irq; // Device interrupt level.

  // The device answers requests and drives the interrupt line.
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata, output irq);

  // The host issues requests.
  modport host (output req, output we, output addr, output wdata, input ack, input rdata, input irq);

endinterface

// >>> core/qirq_host.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// Host controller: AXI4-Lite orders become device register accesses.
// -----------------------------------------------------------------------------
module qirq_host import qirq_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  qirq_if.host bus,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // State of the controller.
  // ---------------------------------------------------------------------------
  typedef enum logic {HS_IDLE, HS_WAIT} qirq_host_phase_t;

  typedef struct packed {
    qirq_host_phase_t phase; // Access phase.
    logic [31:0] command; // Last command word.
    logic [15:0] last_rdata; // Last value read from the device.
    logic aw_ok; // Write address held.
    logic w_ok; // Write data held.
    logic [3:0] aw_addr; // Held write address.
    logic [31:0] w_data; // Held write data.
    logic [3:0] w_strb; // Held byte enables.
    logic awready, wready, bvalid, arready, rvalid, irq; // Bus flags.
    logic [1:0] bresp, rresp; // Responses.
    logic [31:0] rdata; // Read data.
    logic [1:0] ev_status, ev_mask; // Sticky events and mask.
    logic dev_irq_q; // Device line, last cycle.
  } qirq_host_state_t;

  qirq_host_state_t state; // Registered state.
  qirq_host_state_t next_state; // Next state.
  logic [1:0] ev_set; // Events this cycle.
  logic [1:0] ev_clr; // Events cleared this cycle.

  // Merges written bytes into an old word.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] val,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state: AXI slave, device access sequence and events.
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    ev_set = '0;
    ev_clr = '0;

    // Address and data are taken in either order.
    if (awvalid && state.awready) begin
      next_state.aw_ok = 1'b1;
      next_state.aw_addr = awaddr;
    end
    if (wvalid && state.wready) begin
      next_state.w_ok = 1'b1;
      next_state.w_data = wdata;
      next_state.w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end

    // Write performed once both halves are held.
    if (state.aw_ok && state.w_ok && !state.bvalid) begin
      next_state.aw_ok = 1'b0;
      next_state.w_ok = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = AXI_OKAY;
      unique case (state.aw_addr)
        HOFS_COMMAND: begin
          // A command while busy is ignored.
          if (state.phase == HS_IDLE) begin
            next_state.command = merge_bytes(state.command, state.w_data, state.w_strb);
            next_state.phase = HS_WAIT;
          end
        end
        HOFS_IRQ_STATUS: begin
          if (state.w_strb[0]) begin
            ev_clr = state.w_data[1:0];
          end
        end
        HOFS_IRQ_MASK: begin
          next_state.ev_mask = 2'(merge_bytes(32'(state.ev_mask), state.w_data, state.w_strb));
        end
        HOFS_STATUS: begin
          // Read-only word, the write is dropped with an OKAY answer.
        end
        default: begin
          next_state.bresp = AXI_SLVERR;
        end
      endcase
    end

    // Read channel.
    if (rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end
    if (arvalid && state.arready) begin
      next_state.rvalid = 1'b1;
      next_state.rresp = AXI_OKAY;
      unique case (araddr)
        HOFS_COMMAND: begin
          next_state.rdata = state.command;
        end
        HOFS_STATUS: begin
          next_state.rdata = {15'h0000, state.phase == HS_WAIT, state.last_rdata};
        end
        HOFS_IRQ_STATUS: begin
          next_state.rdata = {30'h00000000, state.ev_status};
        end
        HOFS_IRQ_MASK: begin
          next_state.rdata = {30'h00000000, state.ev_mask};
        end
        default: begin
          next_state.rdata = 32'h00000000;
          next_state.rresp = AXI_SLVERR;
        end
      endcase
    end

    // Device access: request held until the device answers.
    if (state.phase == HS_WAIT && bus.ack) begin
      next_state.phase = HS_IDLE;
      ev_set[HEV_DONE] = 1'b1;
      // Data returned by every read command is kept for software.
      if (!state.command[HCMD_WRITE_BIT]) begin
        next_state.last_rdata = bus.rdata;
      end
    end

    // Device interrupt rising edge is an event.
    next_state.dev_irq_q = bus.irq;
    ev_set[HEV_DEV_IRQ] = bus.irq && !state.dev_irq_q;

    // Set wins over a simultaneous clear.
    next_state.ev_status = (state.ev_status & ~ev_clr) | ev_set;
    next_state.irq = |(next_state.ev_status & next_state.ev_mask);

    // Readies drop while a half is held or a response waits.
    next_state.awready = !next_state.aw_ok && !next_state.bvalid;
    next_state.wready = !next_state.w_ok && !next_state.bvalid;
    next_state.arready = !next_state.rvalid;
  end

  // ---------------------------------------------------------------------------
  // State register with synchronous reset.
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs from flip-flops; the request carries the size or data programmed.
  // ---------------------------------------------------------------------------
  assign bus.req = (state.phase == HS_WAIT);
  assign bus.we = state.command[HCMD_WRITE_BIT];
  assign bus.addr = state.command[23:16];
  assign bus.wdata = state.command[15:0];
  assign awready = state.awready;
  assign wready = state.wready;
  assign bvalid = state.bvalid;
  assign bresp = state.bresp;
  assign arready = state.arready;
  assign rvalid = state.rvalid;
  assign rresp = state.rresp;
  assign rdata = state.rdata;
  assign irq = state.irq;

endmodule

// >>> bench/qirq_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------
// Protocol checks on the register link.
// ----------------------------------------
module qirq_asserts import qirq_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Each access gets exactly one acknowledge cycle.
  a_ack_follows_req: assert property (req && !ack |=> ack) else $error("ack missing after request");
  a_ack_single_cycle: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  // The host keeps a request steady and drops it once answered.
  a_req_held_steady: assert property (req && !ack |=> req && $stable({we, addr, wdata})) else $error("request changed");
  a_req_released: assert property (ack |=> !req) else $error("request kept after ack");
  // Read data only moves with a read answer.
  a_rdata_kept: assert property ($changed(rdata) |-> ack && !we) else $error("read data moved");
  a_irq_write_clear: assert property ($fell(irq) |-> ack && we) else $error("irq dropped without write");
  // Unused places and bits read as zero.
  a_unmapped_zero: assert property (ack && !we && addr == 8'h00 |-> rdata == 16'h0000) else $error("unmapped read");
  a_status_bits_only: assert property (ack && !we && addr == OFS_INT_STATUS |-> (rdata & ~STATUS_IMPL_MASK) == 16'h0000)
    else $error("status reserved bit set");
  c_write: cover property (ack && we);
  c_status_read: cover property (ack && !we && addr == OFS_INT_STATUS);
  c_irq_rise: cover property ($rose(irq));
endmodule

// >>> bench/testbench.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bench driving the host over AXI4-Lite and the device events.
// ----------------------------------------
module testbench import qirq_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, dev_irq, host_irq, e_plain, e_delay;
  logic [31:0] wdata = 32'h0, rdata, s;
  logic [1:0] bresp, rresp, r;
  logic [4:0] ev = 5'h00; // Wake frame, packet, link-up, energy, serial error.
  logic [7:0] lvl = 8'h00; // Frames held in the receive queue.
  logic [15:0] free = 16'h0000, q, e = 16'h003C; // Free transmit dwords, last read, expected.
  int n_fail = 0, compares = 0;
  qirq_if link();
  always #20 aclk = ~aclk;
  qirq_device u_qirq_device (.aclk(aclk), .aresetn(aresetn), .bus(link), .wake_frame_evt(ev[4]),
    .wake_packet_evt(ev[3]), .linkup_evt(ev[2]), .energy_evt(ev[1]), .serial_err_evt(ev[0]), .rx_frames_level(lvl),
    .tx_free_dwords(free), .irq(dev_irq), .energy_plain(e_plain), .energy_delayed(e_delay));
  qirq_host u_qirq_host (.aclk(aclk), .aresetn(aresetn), .bus(link), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(host_irq));
  qirq_asserts u_qirq_asserts (.aclk(aclk), .aresetn(aresetn), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .irq(link.irq));
  // AXI write; bready stays high so the answer is taken when it shows.
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    s = rdata;
    r = rresp;
  endtask
  // Device register access through the command register, then wait until idle.
  task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
    axw(HOFS_COMMAND, {w, 7'h00, a, d});
    do begin
      axr(HOFS_STATUS);
    end while (s[HSTAT_BUSY_BIT] !== 1'b0);
    q = s[15:0];
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [4:0] m);
    ev <= m;
    @(posedge aclk);
    ev <= 5'h00;
  endtask
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog: far longer than the whole sequence needs.
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    dev(1'b0, OFS_RX_FRAME_COUNT_THRESHOLD, 16'h0000);
    chk(q, 16'h0000);
    dev(1'b0, OFS_TX_NEXT_REQUEST_SIZE, 16'h0000);
    chk(q, 16'h0000);
    dev(1'b1, OFS_TX_NEXT_REQUEST_SIZE, 16'hA5C3);
    dev(1'b0, OFS_TX_NEXT_REQUEST_SIZE, 16'h0000);
    chk(q, 16'hA5C3);
    dev(1'b0, 8'h00, 16'h0000);
    chk(q, 16'h0000);
    $display("test registers done");
    pulse(5'h1F);
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk(q, 16'h003E);
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk(q, 16'h003E);
    dev(1'b1, OFS_INT_STATUS, 16'hFFFF);
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk(q, e);
    // Each clear pattern in bits 5 to 2 drops exactly one wake flag.
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, OFS_POWER_EVENT_CONTROL, 16'h0020 >> i);
      dev(1'b0, OFS_INT_STATUS, 16'h0000);
      e = e & ~(16'h0020 >> i);
      chk(q, e);
    end
    $display("test wake flags done");
    pulse(5'h02);
    dev(1'b1, OFS_INT_ENABLE, 16'h0004);
    chk({14'h0, e_plain, e_delay}, 16'h0002);
    dev(1'b1, OFS_INT_ENABLE, 16'h0005);
    chk({14'h0, e_plain, e_delay}, 16'h0001);
    chk({15'h0, dev_irq}, 16'h0001);
    dev(1'b1, OFS_POWER_EVENT_CONTROL, 16'h0004);
    chk({15'h0, dev_irq}, 16'h0000);
    $display("test energy done");
    dev(1'b1, OFS_INT_ENABLE, 16'h2040);
    dev(1'b1, OFS_RX_QUEUE_CONTROL, 16'h0020);
    dev(1'b1, OFS_RX_FRAME_COUNT_THRESHOLD, 16'h0003);
    lvl <= 8'h03;
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk(q, 16'h0000);
    lvl <= 8'h04;
    dev(1'b0, OFS_RX_FRAME_COUNT_THRESHOLD, 16'h0000);
    chk(q, 16'h0403);
    chk({15'h0, dev_irq}, 16'h0001);
    lvl <= 8'h06;
    dev(1'b0, OFS_RX_FRAME_COUNT_THRESHOLD, 16'h0000);
    chk(q, 16'h0403);
    $display("test receive threshold done");
    free <= 16'h0010;
    dev(1'b1, OFS_TX_NEXT_REQUEST_SIZE, 16'h0011);
    dev(1'b1, OFS_TX_QUEUE_CONTROL, 16'h0002);
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk(q, 16'h2000);
    free <= 16'h0011;
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk(q, 16'h2040);
    dev(1'b1, OFS_INT_STATUS, 16'h2040);
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk(q, 16'h0000);
    chk({15'h0, dev_irq}, 16'h0000);
    $display("test transmit space done");
    // Host events stay hidden until masked in, then clear by written ones.
    chk({15'h0, host_irq}, 16'h0000);
    axw(HOFS_IRQ_MASK, 32'h0000_0001);
    chk({14'h0, r}, {14'h0, AXI_OKAY});
    axr(HOFS_IRQ_STATUS);
    chk({15'h0, host_irq}, 16'h0001);
    chk({15'h0, s[0]}, 16'h0001);
    axw(HOFS_IRQ_STATUS, 32'h0000_0003);
    axr(HOFS_IRQ_STATUS);
    chk({14'h0, s[1:0]}, 16'h0000);
    chk({15'h0, host_irq}, 16'h0000);
    dev(1'b0, OFS_INT_STATUS, 16'h0000);
    chk({15'h0, host_irq}, 16'h0001);
    axr(4'h1);
    chk({14'h0, r}, {14'h0, AXI_SLVERR});
    $display("test host interrupt done");
    test_done();
  end
endmodule
